// *** cps_pkg.sv ***
//------------------------------------------------------------------------------
// Purpose: shared constants for the cycling preset sequencer
// Assumes: 32-bit APB register bus, one clock, synchronous reset
// Notes:   preset word packs gain, exposure and two override flags
//------------------------------------------------------------------------------
package cps_pkg;

  //----------------------------------------------------------------------------
  // sizes
  //----------------------------------------------------------------------------
  localparam int PRESET_MAX = 8; // stored presets
  localparam int IDX_W = 4; // preset index, counts from 1
  localparam int ADDR_W = 3; // memory address, index minus one
  localparam int GAIN_W = 12;
  localparam int EXPO_W = 16;
  localparam int WORD_W = 30;
  localparam int PADDR_W = 8;

  //----------------------------------------------------------------------------
  // preset word layout
  //----------------------------------------------------------------------------
  localparam int GAIN_LSB = 0;
  localparam int EXPO_LSB = 12;
  localparam int GAIN_ON_BIT = 28;
  localparam int EXPO_ON_BIT = 29;

  //----------------------------------------------------------------------------
  // register byte offsets
  //----------------------------------------------------------------------------
  localparam logic [PADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_PRESET_TOTAL = 8'h04;
  localparam logic [PADDR_W-1:0] OFS_INDEX_SELECT = 8'h08;
  localparam logic [PADDR_W-1:0] OFS_FEATURE_SELECT = 8'h0C;
  localparam logic [PADDR_W-1:0] OFS_FEATURE_ENABLE = 8'h10;
  localparam logic [PADDR_W-1:0] OFS_PRESET_GAIN = 8'h14;
  localparam logic [PADDR_W-1:0] OFS_GLOBAL_GAIN = 8'h18;
  localparam logic [PADDR_W-1:0] OFS_PRESET_EXPO = 8'h1C;
  localparam logic [PADDR_W-1:0] OFS_GLOBAL_EXPO = 8'h20;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h24;

  //----------------------------------------------------------------------------
  // control fields and reset values
  //----------------------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_EVENT_LSB = 1;
  localparam int STATUS_RUN_BIT = 4;
  localparam logic [IDX_W-1:0] FIRST_INDEX = 4'h1;
  localparam logic [IDX_W-1:0] TOTAL_RESET = 4'h1;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h100;
  localparam logic [EXPO_W-1:0] EXPO_RESET = 16'h0064;

  //----------------------------------------------------------------------------
  // enumerations
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    EV_FRAME_END = 2'h0,
    EV_LINE_TRIGGER = 2'h1,
    EV_INPUT_LINE = 2'h2,
    EV_NONE = 2'h3
  } cps_event_t;

  typedef enum logic {
    FEAT_GAIN = 1'b0,
    FEAT_EXPO = 1'b1
  } cps_feature_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } cps_state_t;

endpackage

// *** cps_preset_mem.sv ***
//------------------------------------------------------------------------------
// Purpose: preset storage, one write port and two registered read ports
// Assumes: synchronous reset clears every preset
// Notes:   read data lag the address by one clock
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module cps_preset_mem (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic wrEn, // write strobe
  input wire logic [cps_pkg::ADDR_W-1:0] wrAddr, // write address
  input wire logic [cps_pkg::WORD_W-1:0] wrData, // write word
  input wire logic [cps_pkg::ADDR_W-1:0] rdAddrA, // software read address
  output logic [cps_pkg::WORD_W-1:0] rdDataA, // software read word
  input wire logic [cps_pkg::ADDR_W-1:0] rdAddrB, // sequencer read address
  output logic [cps_pkg::WORD_W-1:0] rdDataB // sequencer read word
);
  import cps_pkg::*;

  logic [WORD_W-1:0] store [PRESET_MAX];

  //----------------------------------------------------------------------------
  // storage and read registers
  //----------------------------------------------------------------------------
  // clear on reset so override flags start off
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < PRESET_MAX; i++) begin
        store[i] <= '0;
      end
    end else if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // both ports registered
  always_ff @(posedge clk) begin
    if (reset) begin
      rdDataA <= '0;
      rdDataB <= '0;
    end else begin
      rdDataA <= store[rdAddrA];
      rdDataB <= store[rdAddrB];
    end
  end

endmodule

// *** cps_sequencer.sv ***
//------------------------------------------------------------------------------
// Purpose: cycling preset sequencer with APB register access
// Assumes: acquisition events are one-cycle pulses at least two clocks apart
// Notes:   reads take one wait state, writes none
//------------------------------------------------------------------------------
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
module cps_sequencer (
  input wire logic clk, // 100 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [cps_pkg::PADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic acquisitionActive, // level, acquisition running
  input wire logic frameEndEvent, // pulse, end of frame
  input wire logic lineTriggerEvent, // pulse, valid line trigger
  input wire logic inputLineEvent, // pulse, input line event
  output logic [cps_pkg::GAIN_W-1:0] sensorGain, // gain to the sensor
  output logic [cps_pkg::EXPO_W-1:0] sensorExposure, // exposure to the sensor
  output logic [cps_pkg::IDX_W-1:0] activeIndex, // preset in use, 0 when idle
  output logic sequencerRunning // level, cycling in progress
);
  import cps_pkg::*;

  //----------------------------------------------------------------------------
  // index helpers
  //----------------------------------------------------------------------------
  // successor index with wrap after the last preset
  function automatic logic [IDX_W-1:0] nextIndexOf(input logic [IDX_W-1:0] idx,
                                                   input logic [IDX_W-1:0] total);
    nextIndexOf = (idx >= total) ? FIRST_INDEX : idx + FIRST_INDEX;
  endfunction

  // memory address of a one-based index
  function automatic logic [ADDR_W-1:0] addrOf(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] zeroBased;
    zeroBased = idx - FIRST_INDEX;
    addrOf = zeroBased[ADDR_W-1:0];
  endfunction

  // clamp a written index or total into 1..PRESET_MAX
  function automatic logic [IDX_W-1:0] clampIndex(input logic [31:0] value);
    if (value == 32'h0) begin
      clampIndex = FIRST_INDEX;
    end else if (value > 32'(PRESET_MAX)) begin
      clampIndex = IDX_W'(PRESET_MAX);
    end else begin
      clampIndex = value[IDX_W-1:0];
    end
  endfunction

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  logic sequencerEnable;
  cps_event_t advanceEventSelect;
  logic [IDX_W-1:0] presetTotal;
  logic [IDX_W-1:0] presetIndexSelect;
  cps_feature_t overrideFeatureSelect;
  logic [GAIN_W-1:0] globalGain;
  logic [EXPO_W-1:0] globalExposure;
  logic [PRESET_MAX-1:0] gainOnMask;
  logic readWait;
  cps_state_t state;
  cps_state_t next_state;
  logic [IDX_W-1:0] currentIndex;
  logic [WORD_W-1:0] appliedWord;
  logic [WORD_W-1:0] selWord;
  logic [WORD_W-1:0] upWord;

  //----------------------------------------------------------------------------
  // APB decode
  //----------------------------------------------------------------------------
  wire accessPhase = psel & penable;
  wire hitCtrl = (paddr == OFS_CTRL);
  wire hitTotal = (paddr == OFS_PRESET_TOTAL);
  wire hitSelect = (paddr == OFS_INDEX_SELECT);
  wire hitFeature = (paddr == OFS_FEATURE_SELECT);
  wire hitEnable = (paddr == OFS_FEATURE_ENABLE);
  wire hitPGain = (paddr == OFS_PRESET_GAIN);
  wire hitGGain = (paddr == OFS_GLOBAL_GAIN);
  wire hitPExpo = (paddr == OFS_PRESET_EXPO);
  wire hitGExpo = (paddr == OFS_GLOBAL_EXPO);
  wire hitStatus = (paddr == OFS_STATUS);
  wire addrMapped = hitCtrl | hitTotal | hitSelect | hitFeature | hitEnable | hitPGain
                    | hitGGain | hitPExpo | hitGExpo | hitStatus;
  wire readAccess = accessPhase & ~pwrite;
  wire readCapture = readAccess & ~readWait;
  wire wrStrobe = accessPhase & pwrite & addrMapped;

  // reads wait one cycle so the memory port has settled
  assign pready = ~readAccess | readWait;
  assign pslverr = accessPhase & pready & ~addrMapped;

  //----------------------------------------------------------------------------
  // preset access from software
  //----------------------------------------------------------------------------
  wire [ADDR_W-1:0] selAddr = addrOf(presetIndexSelect);
  wire selGainOn = selWord[GAIN_ON_BIT];
  wire selExpoOn = selWord[EXPO_ON_BIT];
  wire enableBit = pwdata[0];
  wire wrFeatureEnable = wrStrobe & hitEnable;
  wire wrPresetGain = wrStrobe & hitPGain;
  wire wrPresetExpo = wrStrobe & hitPExpo;
  wire memWrite = wrFeatureEnable | wrPresetGain | wrPresetExpo;
  wire gainTurningOn = wrFeatureEnable & (overrideFeatureSelect == FEAT_GAIN)
                       & enableBit & ~selGainOn;
  wire gainLocked = sequencerEnable & (|gainOnMask);

  // read-modify-write of the selected preset word
  logic [WORD_W-1:0] memWrData;
  always_comb begin
    memWrData = selWord;
    if (wrFeatureEnable && overrideFeatureSelect == FEAT_GAIN) begin
      memWrData[GAIN_ON_BIT] = enableBit;
    end
    if (wrFeatureEnable && overrideFeatureSelect == FEAT_EXPO) begin
      memWrData[EXPO_ON_BIT] = enableBit;
    end
    if (gainTurningOn) begin
      memWrData[GAIN_LSB +: GAIN_W] = globalGain;
    end
    if (wrPresetGain) begin
      memWrData[GAIN_LSB +: GAIN_W] = pwdata[GAIN_W-1:0];
    end
    if (wrPresetExpo) begin
      memWrData[EXPO_LSB +: EXPO_W] = pwdata[EXPO_W-1:0];
    end
  end

  //----------------------------------------------------------------------------
  // sequencing control
  //----------------------------------------------------------------------------
  wire running = (state == ST_RUN);
  wire startCycling = sequencerEnable & acquisitionActive;
  wire eventSeen = (advanceEventSelect == EV_FRAME_END) ? frameEndEvent
                 : (advanceEventSelect == EV_LINE_TRIGGER) ? lineTriggerEvent
                 : (advanceEventSelect == EV_INPUT_LINE) ? inputLineEvent
                 : 1'b0;
  wire advance = running & startCycling & eventSeen;
  wire beginRun = (state == ST_IDLE) & startCycling;
  wire [IDX_W-1:0] upcomingIndex = running ? nextIndexOf(currentIndex, presetTotal)
                                           : FIRST_INDEX;
  wire [ADDR_W-1:0] upAddr = addrOf(upcomingIndex);

  // run while enabled and acquiring
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (startCycling) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!startCycling) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  //----------------------------------------------------------------------------
  // preset storage
  //----------------------------------------------------------------------------
  cps_preset_mem presetMem (
    .clk(clk),
    .reset(reset),
    .wrEn(memWrite),
    .wrAddr(selAddr),
    .wrData(memWrData),
    .rdAddrA(selAddr),
    .rdDataA(selWord),
    .rdAddrB(upAddr),
    .rdDataB(upWord)
  );

  //----------------------------------------------------------------------------
  // registers written by software
  //----------------------------------------------------------------------------
  // configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      sequencerEnable <= 1'b0;
      advanceEventSelect <= EV_FRAME_END;
      presetTotal <= TOTAL_RESET;
      presetIndexSelect <= FIRST_INDEX;
      overrideFeatureSelect <= FEAT_GAIN;
    end else if (wrStrobe) begin
      if (hitCtrl) begin
        sequencerEnable <= pwdata[CTRL_ENABLE_BIT];
        advanceEventSelect <= cps_event_t'(pwdata[CTRL_EVENT_LSB +: 2]);
      end
      if (hitTotal) begin
        presetTotal <= clampIndex(pwdata);
      end
      if (hitSelect) begin
        presetIndexSelect <= clampIndex(pwdata);
      end
      if (hitFeature) begin
        overrideFeatureSelect <= cps_feature_t'(pwdata[0]);
      end
    end
  end

  // global settings; gain ignores writes while presets own it
  always_ff @(posedge clk) begin
    if (reset) begin
      globalGain <= GAIN_RESET;
      globalExposure <= EXPO_RESET;
    end else begin
      if (wrStrobe && hitGGain && !gainLocked) begin
        globalGain <= pwdata[GAIN_W-1:0];
      end
      if (wrStrobe && hitGExpo) begin
        globalExposure <= pwdata[EXPO_W-1:0];
      end
    end
  end

  // which presets hold a gain override
  always_ff @(posedge clk) begin
    if (reset) begin
      gainOnMask <= '0;
    end else if (wrFeatureEnable && overrideFeatureSelect == FEAT_GAIN) begin
      gainOnMask[selAddr] <= enableBit;
    end
  end

  //----------------------------------------------------------------------------
  // sequencer registers
  //----------------------------------------------------------------------------
  // index and the preset in use change at start or on the event; index clears to 0 while not enabled and acquiring
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      currentIndex <= '0;
      appliedWord <= '0;
    end else begin
      state <= next_state;
      if (beginRun || advance) begin
        currentIndex <= upcomingIndex;
        appliedWord <= upWord;
      end else if (!startCycling) begin
        currentIndex <= '0;
      end
    end
  end

  // sensor values: preset override while running, else global
  always_ff @(posedge clk) begin
    if (reset) begin
      sensorGain <= GAIN_RESET;
      sensorExposure <= EXPO_RESET;
    end else begin
      sensorGain <= (running && appliedWord[GAIN_ON_BIT])
                    ? appliedWord[GAIN_LSB +: GAIN_W] : globalGain;
      sensorExposure <= (running && appliedWord[EXPO_ON_BIT])
                        ? appliedWord[EXPO_LSB +: EXPO_W] : globalExposure;
    end
  end

  assign activeIndex = currentIndex;
  assign sequencerRunning = running;

  //----------------------------------------------------------------------------
  // read path
  //----------------------------------------------------------------------------
  wire selFeatureOn = (overrideFeatureSelect == FEAT_GAIN) ? selGainOn : selExpoOn;
  wire [31:0] readMux =
      hitCtrl ? {29'h0, advanceEventSelect, sequencerEnable}
    : hitTotal ? {28'h0, presetTotal}
    : hitSelect ? {28'h0, presetIndexSelect}
    : hitFeature ? {31'h0, overrideFeatureSelect}
    : hitEnable ? {31'h0, selFeatureOn}
    : hitPGain ? {20'h0, selWord[GAIN_LSB +: GAIN_W]}
    : hitGGain ? {19'h0, gainLocked, globalGain}
    : hitPExpo ? {16'h0, selWord[EXPO_LSB +: EXPO_W]}
    : hitGExpo ? {16'h0, globalExposure}
    : hitStatus ? {27'h0, running, currentIndex}
    : 32'h0;

  // wait flag and captured read data
  always_ff @(posedge clk) begin
    if (reset) begin
      readWait <= 1'b0;
      prdata <= '0;
    end else begin
      readWait <= readCapture;
      if (readCapture) begin
        prdata <= readMux;
      end
    end
  end

endmodule

// *** cps_sequencer_assertions.sv ***
// Purpose: port-level checks for the cycling preset sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/10ps
module cps_sequencer_assertions (
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [cps_pkg::PADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic acquisitionActive, // acquisition level
  input wire logic frameEndEvent, // event pulse
  input wire logic lineTriggerEvent, // event pulse
  input wire logic inputLineEvent, // event pulse
  input wire logic [cps_pkg::GAIN_W-1:0] sensorGain, // sensor gain
  input wire logic [cps_pkg::EXPO_W-1:0] sensorExposure, // sensor exposure
  input wire logic [cps_pkg::IDX_W-1:0] activeIndex, // preset in use
  input wire logic sequencerRunning // cycling flag
);
  import cps_pkg::*;
  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  // any of the three acquisition events
  wire anyEvent = frameEndEvent | lineTriggerEvent | inputLineEvent;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_readSetup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  //----------------------------------------------------------------------------
  // properties
  //----------------------------------------------------------------------------
  property p_readWait;
    s_readSetup ##1 s_access |-> !pready ##1 pready;
  endproperty
  property p_writeReady;
    s_access ##0 pwrite |-> pready;
  endproperty
  property p_unmapped;
    psel && penable && pready && paddr > 8'h24 |-> pslverr;
  endproperty
  property p_mapped;
    psel && penable && pready && paddr <= 8'h24 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_idle;
    !acquisitionActive [*3] |-> activeIndex == 4'h0 && !sequencerRunning;
  endproperty
  property p_start;
    $rose(sequencerRunning) |-> ##[0:1] activeIndex == FIRST_INDEX;
  endproperty
  property p_range;
    sequencerRunning && $past(sequencerRunning, 2) |-> activeIndex != 4'h0 && activeIndex <= 4'h8;
  endproperty
  property p_advance;
    sequencerRunning && $past(sequencerRunning, 3) && activeIndex != $past(activeIndex)
      |-> $past(anyEvent) || $past(anyEvent, 2);
  endproperty
  property p_step;
    $past(activeIndex) != 4'h0 && activeIndex != 4'h0 && activeIndex != $past(activeIndex)
      |-> activeIndex == $past(activeIndex) + 4'h1 || activeIndex == 4'h1;
  endproperty
  property p_sensorHold;
    sequencerRunning && $past(sequencerRunning, 3) && $stable(activeIndex)
      && $past(activeIndex) == $past(activeIndex, 2) && $past(activeIndex) == $past(activeIndex, 3)
      && !$past(psel) && !$past(psel, 2) && !$past(psel, 3)
      |-> $stable(sensorGain) && $stable(sensorExposure);
  endproperty
  a_readWait: assert property (p_readWait) else $error("read without one wait state");
  a_writeReady: assert property (p_writeReady) else $error("write not ready");
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
  a_mapped: assert property (p_mapped) else $error("error on mapped address");
  a_idle: assert property (p_idle) else $error("index kept while idle");
  a_start: assert property (p_start) else $error("cycling not started at 1");
  a_range: assert property (p_range) else $error("index out of range");
  a_advance: assert property (p_advance) else $error("index moved with no event");
  a_step: assert property (p_step) else $error("index skipped");
  a_sensorHold: assert property (p_sensorHold) else $error("sensor moved between events");
endmodule
bind cps_sequencer cps_sequencer_assertions u_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .acquisitionActive(acquisitionActive), .frameEndEvent(frameEndEvent),
  .lineTriggerEvent(lineTriggerEvent), .inputLineEvent(inputLineEvent),
  .sensorGain(sensorGain), .sensorExposure(sensorExposure), .activeIndex(activeIndex),
  .sequencerRunning(sequencerRunning)
);

// *** cps_sequencer_tb_top.sv ***
// Purpose: self-checking bench for the cycling preset sequencer
// Assumes: apb timing as handed over, events two or more clocks apart
// Notes:   gain overrides on presets 1 to 3, total of three
`timescale 1ns/10ps
module cps_sequencer_tb_top;
  import cps_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic acquisitionActive = 1'b0;
  logic [2:0] ev = 3'h0; // frame end, line trigger, input line
  logic [GAIN_W-1:0] sensorGain;
  logic [EXPO_W-1:0] sensorExposure;
  logic [IDX_W-1:0] activeIndex;
  logic sequencerRunning;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rdData;
  logic rdErr;
  logic [IDX_W-1:0] expIdx;
  logic [EXPO_W-1:0] expExpo = 16'h0064;
  logic [GAIN_W-1:0] gainOf [0:3];
  //----------------------------------------------------------------------------
  // design and clock
  //----------------------------------------------------------------------------
  cps_sequencer u_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acquisitionActive(acquisitionActive), .frameEndEvent(ev[0]),
    .lineTriggerEvent(ev[1]), .inputLineEvent(ev[2]), .sensorGain(sensorGain),
    .sensorExposure(sensorExposure), .activeIndex(activeIndex),
    .sequencerRunning(sequencerRunning)
  );
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  //----------------------------------------------------------------------------
  // tasks
  //----------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rdData, exp);
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    ev[which] <= 1'b1;
    @(posedge clk);
    ev[which] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic seqChk();
    #1;
    check("activeIndex", {28'h0, activeIndex}, {28'h0, expIdx});
    check("sensorGain", {20'h0, sensorGain}, {20'h0, gainOf[expIdx]});
    check("sensorExposure", {16'h0, sensorExposure}, {16'h0, expExpo});
    check("sequencerRunning", {31'h0, sequencerRunning}, {31'h0, expIdx != 4'h0});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  //----------------------------------------------------------------------------
  // tests
  //----------------------------------------------------------------------------
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdChk("ctrl", OFS_CTRL, 32'h0);
    rdChk("total", OFS_PRESET_TOTAL, 32'h1);
    rdChk("globalGain", OFS_GLOBAL_GAIN, 32'h100);
    apb(1'b0, 8'h40, 32'h0);
    check("unmappedErr", {31'h0, rdErr}, 32'h1);
    $display("test reset values done");
    apb(1'b1, OFS_GLOBAL_GAIN, 32'h0AB);
    gainOf[0] = 12'h0AB;
    gainOf[1] = 12'h150;
    gainOf[2] = 12'h200;
    gainOf[3] = 12'h300;
    apb(1'b1, OFS_FEATURE_SELECT, 32'h0);
    for (int i = 1; i <= 3; i++) begin
      apb(1'b1, OFS_INDEX_SELECT, 32'(i));
      apb(1'b1, OFS_FEATURE_ENABLE, 32'h1);
      rdChk("seededGain", OFS_PRESET_GAIN, 32'h0AB);
      apb(1'b1, OFS_PRESET_GAIN, {20'h0, gainOf[i]});
      rdChk("presetGain", OFS_PRESET_GAIN, {20'h0, gainOf[i]});
    end
    apb(1'b1, OFS_PRESET_TOTAL, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_GLOBAL_GAIN, 32'h555);
    rdChk("gainLock", OFS_GLOBAL_GAIN, 32'h10AB);
    $display("test preset programming done");
    acquisitionActive <= 1'b1;
    expIdx = 4'h1;
    repeat (4) @(posedge clk);
    seqChk();
    // every event source, each pulse on every input
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, OFS_CTRL, 32'(2 * e + 1));
      for (int w = 0; w < 3; w++) begin
        pulse(w);
        if (w == e) expIdx = (expIdx == 4'h3) ? 4'h1 : expIdx + 4'h1;
        seqChk();
      end
    end
    $display("test event sources done");
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_INDEX_SELECT, 32'h2);
    apb(1'b1, OFS_PRESET_GAIN, 32'h2CD);
    gainOf[2] = 12'h2CD;
    seqChk();
    pulse(0);
    expIdx = 4'h2;
    seqChk();
    rdChk("statusRun", OFS_STATUS, 32'h12);
    $display("test live rewrite done");
    apb(1'b1, OFS_CTRL, 32'h0);
    expIdx = 4'h0;
    pulse(0);
    seqChk();
    apb(1'b1, OFS_CTRL, 32'h1);
    expIdx = 4'h1;
    repeat (4) @(posedge clk);
    seqChk();
    @(posedge clk);
    acquisitionActive <= 1'b0;
    expIdx = 4'h0;
    repeat (4) @(posedge clk);
    seqChk();
    rdChk("status", OFS_STATUS, 32'h0);
    $display("test enable and stop done");
    // exposure follows global while idle, then preset 2 overrides it
    apb(1'b1, OFS_GLOBAL_EXPO, 32'h200);
    expExpo = 16'h0200;
    repeat (2) @(posedge clk);
    seqChk();
    apb(1'b1, OFS_FEATURE_SELECT, 32'h1);
    apb(1'b1, OFS_FEATURE_ENABLE, 32'h1);
    apb(1'b1, OFS_PRESET_EXPO, 32'h345);
    rdChk("presetExpo", OFS_PRESET_EXPO, 32'h345);
    rdChk("expoEnable", OFS_FEATURE_ENABLE, 32'h1);
    acquisitionActive <= 1'b1;
    expIdx = 4'h1;
    repeat (4) @(posedge clk);
    seqChk();
    pulse(0);
    expIdx = 4'h2;
    expExpo = 16'h0345;
    seqChk();
    $display("test exposure override done");
    end_of_test();
  end
endmodule
